// ==== src/irq_pkg.sv ====
// shared constants and carrier types of the interrupt source block
package irq_pkg;

    // ------------------------------------------------------------
    // source numbering (index equals default priority)
    // ------------------------------------------------------------
    localparam int NUM_MASKABLE = 22;
    localparam int IDX_W        = 5;
    localparam int IDX_WDT      = 0;
    localparam int IDX_PIN0     = 1;
    localparam int IDX_REM_EDGE = 5;
    localparam int IDX_SER_A    = 6;
    localparam int IDX_SER_B    = 7;
    localparam int IDX_UART_TX  = 8;
    localparam int IDX_WATCH_IV = 9;
    localparam int IDX_TIMER_A  = 10;
    localparam int IDX_TIMER_B  = 11;
    localparam int IDX_TIMER_C  = 12;
    localparam int IDX_TIMER_D  = 13;
    localparam int IDX_ADC      = 14;
    localparam int IDX_WATCH_OV = 15;
    localparam int IDX_KEY0     = 16;
    localparam int IDX_REM_ERR  = 17;
    localparam int IDX_REM_GP   = 18;
    localparam int IDX_REM_DONE = 19;
    localparam int IDX_REM_FULL = 20;
    localparam int IDX_KEY1     = 21;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [21:0] FLAG_RESET = 22'h000000;
    localparam logic [21:0] MASK_RESET = 22'h3fffff;
    localparam logic [2:0]  SYNC_RESET = 3'h0;

    // ------------------------------------------------------------
    // vector table
    // ------------------------------------------------------------
    localparam logic [15:0] NMI_VECTOR = 16'h0004;
    localparam logic [15:0] VECTOR_TABLE [0:21] = '{
        16'h0004, 16'h0006, 16'h0008, 16'h000a, 16'h000c, 16'h000e,
        16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001a,
        16'h001c, 16'h001e, 16'h0020, 16'h0022, 16'h0024, 16'h0026,
        16'h0028, 16'h002a, 16'h002c, 16'h002e
    };

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        EDGE_FALL = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_NONE = 2'h2,
        EDGE_BOTH = 2'h3
    } edge_mode_t;

    typedef struct packed {
        logic remote_edge;
        logic uart_rx_done;
        logic serial_a_xfer_done;
        logic serial_b_xfer_done;
        logic uart_tx_done;
        logic watch_interval;
        logic timer_a_match;
        logic timer_b_match;
        logic timer_c_match;
        logic timer_bc_match16;
        logic timer_16bit_mode;
        logic timer_d_match;
        logic adc_done;
        logic watch_overflow;
        logic remote_error;
        logic remote_guide_pulse;
        logic remote_rx_done;
        logic remote_shift_full;
    } periph_events_t;

    typedef struct packed {
        logic             req;
        logic             nmi;
        logic [15:0]      vector;
        logic [IDX_W-1:0] index;
    } core_req_t;

    typedef struct packed {
        logic [21:0] flags;
        logic [21:0] mask;
        core_req_t   out;
        logic        wake;
    } ctrl_state_t;

    typedef struct packed {
        logic [2:0] sync;
        logic       level;
        logic [1:0] primed;
        logic       edge_seen;
    } edge_state_t;

endpackage

// ==== src/pin_edge_detect.sv ====
// synchronised edge detector for one external interrupt pin
`timescale 1ns/100ps
module pin_edge_detect
(
    input  wire logic               clock_i,
    input  wire logic               rst_n_i,
    input  wire logic               pin_i,
    input  wire irq_pkg::edge_mode_t mode_i,
    output logic                    edge_o
);

    irq_pkg::edge_state_t state_reg;
    irq_pkg::edge_state_t state_next;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_next           = state_reg;
        state_next.sync      = {state_reg.sync[1:0], pin_i};
        state_next.edge_seen = 1'b0;
        // stages hold reset zeros, not pin samples, for three edges
        if (state_reg.primed != 2'h3)
        begin
            state_next.level  = state_reg.sync[1];
            state_next.primed = state_reg.primed + 2'h1;
        end
        // stages two and three must agree before a change counts
        else if (state_reg.sync[2] == state_reg.sync[1]
                 && state_reg.level != state_reg.sync[2])
        begin
            state_next.level = state_reg.sync[2];
            case (mode_i)
                irq_pkg::EDGE_RISE: state_next.edge_seen = state_reg.sync[2];
                irq_pkg::EDGE_FALL: state_next.edge_seen = ~state_reg.sync[2];
                irq_pkg::EDGE_BOTH: state_next.edge_seen = 1'b1;
                default:            state_next.edge_seen = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            state_reg.sync      <= irq_pkg::SYNC_RESET;
            state_reg.level     <= 1'b0;
            state_reg.primed    <= 2'h0;
            state_reg.edge_seen <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign edge_o = state_reg.edge_seen;

endmodule // pin_edge_detect

// ==== src/prio_pick.sv ====
// fixed priority picker, lowest index wins
`timescale 1ns/100ps
module prio_pick
#(
    parameter int N     = 22,
    parameter int IDX_W = 5
)
(
    input  wire logic [N-1:0]     req_i,
    output logic                  found_o,
    output logic [IDX_W-1:0]      idx_o
);

    always_comb
    begin
        found_o = 1'b0;
        idx_o   = '0;
        // scan downward so the lowest set index is kept last
        for (int i = N - 1; i >= 0; i--)
        begin
            if (req_i[i])
            begin
                found_o = 1'b1;
                idx_o   = IDX_W'(i);
            end
        end
    end

endmodule // prio_pick

// ==== src/interrupt_source_priority_vectoring.sv ====
// interrupt source collection, flags, masks, priority and vectoring
//
// Contract
// - 22 sources in small variant, 23 with the second key return source.
// - watchdog overflow in mode 1 raises non-maskable request, vector 0004H.
// - watchdog overflow in interval mode is maskable request, priority 0.
// - only one watchdog request kind selected at any time.
// - simultaneous maskable requests: lowest default priority number granted.
// - external pins 0..3 edges: priorities 1..4, vectors 0006H..000CH.
// - remote edge detection: priority 5, vector 000EH.
// - uart receive and serial A transfer end share priority 6, 0010H.
// - serial B transfer end: priority 7, vector 0012H.
// - uart transmit end: priority 8, vector 0014H.
// - watch interval signal: priority 9, vector 0016H.
// - timer A match priority 10 0018H, timer B priority 11 001AH.
// - timer C match or 16-bit combined match: priority 12, 001CH.
// - timer D match: priority 13, vector 001EH.
// - adc conversion end: priority 14, vector 0020H.
// - watch overflow: priority 15, vector 0022H.
// - key return 0 priority 16 0024H; key return 1 priority 21 002EH.
// - remote reception error: priority 17, vector 0026H.
// - remote guide pulse: priority 18, vector 0028H.
// - remote reception complete: priority 19, vector 002AH.
// - remote shift data read request: priority 20, vector 002CH.
// - flag set by event or software; cleared by ack, reset, software (in nmi mode software can neither set nor clear the watchdog flag).
// - after reset flags read zero and masks read one.
`timescale 1ns/100ps
module interrupt_source_priority_vectoring
#(
    parameter bit LARGE_VARIANT = 1'b0
)
(
    input  wire logic                   clock_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   wdt_overflow_i,
    input  wire logic                   wdt_nmi_mode_i,
    input  wire logic [3:0]             ext_pin_i,
    input  wire irq_pkg::edge_mode_t [3:0] ext_edge_mode_i,
    input  wire logic [1:0]             key_return_i,
    input  wire logic [1:0]             key_return_mode_i,
    input  wire irq_pkg::periph_events_t periph_i,
    input  wire logic [21:0]            sw_flag_set_i,
    input  wire logic [21:0]            sw_flag_clr_i,
    input  wire logic                   sw_mask_wr_i,
    input  wire logic [21:0]            sw_mask_i,
    input  wire logic                   global_irq_enable_i,
    input  wire logic                   ack_i,
    output irq_pkg::core_req_t          core_req_o,
    output logic [21:0]                 flags_o,
    output logic [21:0]                 mask_o,
    output logic                        wake_o
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    irq_pkg::ctrl_state_t state_reg;
    irq_pkg::ctrl_state_t state_next;

    logic [3:0]           ext_edge;
    logic [1:0]           key_edge;
    logic [21:0]          events;
    logic [21:0]          present;
    logic [21:0]          sw_set_ok;
    logic [21:0]          sw_clr_ok;
    logic [21:0]          ack_clr;
    logic [21:0]          flags_new;
    logic [21:0]          mask_new;
    logic [21:0]          pending;
    logic                 pick_found;
    logic [4:0]           pick_idx;
    logic                 nmi_pending;

    // ------------------------------------------------------------
    // source population
    // ------------------------------------------------------------
    // second key return source exists only in the large variant
    always_comb
    begin
        present                    = '1;
        present[irq_pkg::IDX_KEY1] = LARGE_VARIANT;
    end

    // ------------------------------------------------------------
    // external pin edge detection
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : gen_ext_pin
            pin_edge_detect u_ext_edge
            (
                .clock_i (clock_i),
                .rst_n_i (rst_n_i),
                .pin_i   (ext_pin_i[g]),
                .mode_i  (ext_edge_mode_i[g]),
                .edge_o  (ext_edge[g])
            );
        end
        // key return inputs report a falling edge when enabled
        for (g = 0; g < 2; g++)
        begin : gen_key_ret
            pin_edge_detect u_key_edge
            (
                .clock_i (clock_i),
                .rst_n_i (rst_n_i),
                .pin_i   (key_return_i[g]),
                .mode_i  (key_return_mode_i[g] ? irq_pkg::EDGE_FALL
                                               : irq_pkg::EDGE_NONE),
                .edge_o  (key_edge[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // event mapping onto priority slots
    // ------------------------------------------------------------
    always_comb
    begin
        events = '0;
        // watchdog overflow lands in slot 0 in either mode
        // in interval mode slot 0 is the top maskable request
        events[irq_pkg::IDX_WDT] = wdt_overflow_i;
        // pin edges take slots 1 to 4
        events[irq_pkg::IDX_PIN0 +: 4] = ext_edge;
        events[irq_pkg::IDX_REM_EDGE] = periph_i.remote_edge;
        // two serial events share one slot
        events[irq_pkg::IDX_SER_A] = periph_i.uart_rx_done
                                   | periph_i.serial_a_xfer_done;
        events[irq_pkg::IDX_SER_B] = periph_i.serial_b_xfer_done;
        events[irq_pkg::IDX_UART_TX] = periph_i.uart_tx_done;
        events[irq_pkg::IDX_WATCH_IV] = periph_i.watch_interval;
        events[irq_pkg::IDX_TIMER_A] = periph_i.timer_a_match;
        events[irq_pkg::IDX_TIMER_B] = periph_i.timer_b_match;
        // source chosen by the timer's counting width
        events[irq_pkg::IDX_TIMER_C] = periph_i.timer_16bit_mode
                                     ? periph_i.timer_bc_match16
                                     : periph_i.timer_c_match;
        events[irq_pkg::IDX_TIMER_D] = periph_i.timer_d_match;
        events[irq_pkg::IDX_ADC] = periph_i.adc_done;
        events[irq_pkg::IDX_WATCH_OV] = periph_i.watch_overflow;
        // key return detections, second gated by population
        events[irq_pkg::IDX_KEY0] = key_edge[0];
        events[irq_pkg::IDX_KEY1] = key_edge[1] & LARGE_VARIANT;
        events[irq_pkg::IDX_REM_ERR] = periph_i.remote_error;
        events[irq_pkg::IDX_REM_GP] = periph_i.remote_guide_pulse;
        events[irq_pkg::IDX_REM_DONE] = periph_i.remote_rx_done;
        // shift data ready to be read
        events[irq_pkg::IDX_REM_FULL] = periph_i.remote_shift_full;
    end

    // ------------------------------------------------------------
    // software access qualification
    // ------------------------------------------------------------
    always_comb
    begin
        sw_set_ok = sw_flag_set_i & present;
        sw_clr_ok = sw_flag_clr_i;
        // watchdog flag is hardware-owned while it drives the nmi
        if (wdt_nmi_mode_i)
        begin
            sw_set_ok[irq_pkg::IDX_WDT] = 1'b0;
            sw_clr_ok[irq_pkg::IDX_WDT] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // acknowledge decode
    // ------------------------------------------------------------
    always_comb
    begin
        ack_clr = '0;
        // ack only counts against a request actually presented
        if (ack_i && state_reg.out.req)
        begin
            ack_clr[state_reg.out.index] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // flag and mask update
    // ------------------------------------------------------------
    always_comb
    begin
        // event or software set, wins over any clear
        flags_new = ((state_reg.flags & ~sw_clr_ok & ~ack_clr)
                     | sw_set_ok | events) & present;
        mask_new = state_reg.mask;
        if (sw_mask_wr_i)
        begin
            // absent sources stay masked whatever software writes
            mask_new = sw_mask_i | ~present;
        end
    end

    // ------------------------------------------------------------
    // request qualification
    // ------------------------------------------------------------
    always_comb
    begin
        // flag set, mask clear and global enable set
        pending = flags_new & ~mask_new & {22{global_irq_enable_i}};
        // the watchdog slot is non-maskable or maskable, never both
        if (wdt_nmi_mode_i)
        begin
            pending[irq_pkg::IDX_WDT] = 1'b0;
        end
        nmi_pending = flags_new[irq_pkg::IDX_WDT] & wdt_nmi_mode_i;
    end

    // lowest numbered pending slot is granted
    prio_pick
    #(
        .N     (irq_pkg::NUM_MASKABLE),
        .IDX_W (irq_pkg::IDX_W)
    )
    u_prio_pick
    (
        .req_i   (pending),
        .found_o (pick_found),
        .idx_o   (pick_idx)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_next       = state_reg;
        state_next.flags = flags_new;
        state_next.mask  = mask_new;
        // non-maskable request always outranks the maskable ones
        if (nmi_pending)
        begin
            state_next.out.req    = 1'b1;
            state_next.out.nmi    = 1'b1;
            state_next.out.vector = irq_pkg::NMI_VECTOR;
            state_next.out.index  = irq_pkg::IDX_W'(irq_pkg::IDX_WDT);
        end
        else
        begin
            state_next.out.req    = pick_found;
            state_next.out.nmi    = 1'b0;
            state_next.out.vector = pick_found
                                  ? irq_pkg::VECTOR_TABLE[pick_idx]
                                  : 16'h0000;
            state_next.out.index  = pick_idx;
        end
        // standby release ignores the global enable
        state_next.wake = nmi_pending
                        | (|(flags_new & ~mask_new & ~{21'h000000,
                                                       wdt_nmi_mode_i}));
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            // flags clear, every maskable source masked
            state_reg.flags <= irq_pkg::FLAG_RESET;
            state_reg.mask  <= irq_pkg::MASK_RESET;
            state_reg.out   <= '0;
            state_reg.wake  <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign core_req_o = state_reg.out;
    assign flags_o    = state_reg.flags;
    assign mask_o     = state_reg.mask;
    assign wake_o     = state_reg.wake;

endmodule // interrupt_source_priority_vectoring

// ==== test/irq_src_properties.sv ====
// assertion checker bound to the interrupt source block
`timescale 1ns/100ps
module irq_src_properties
#(
    parameter bit LARGE_VARIANT = 1'b0
)
(
    input wire logic               clock_i,
    input wire logic               rst_n_i,
    input wire logic               wdt_nmi_mode_i,
    input wire logic [21:0]        sw_flag_set_i,
    input wire logic               sw_mask_wr_i,
    input wire logic [21:0]        sw_mask_i,
    input wire logic               ack_i,
    input wire irq_pkg::core_req_t core_req_o,
    input wire logic [21:0]        flags_o,
    input wire logic [21:0]        mask_o
);
    // ----------------
    // sequences
    // ----------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sequence ack_taken;
        ack_i && core_req_o.req && sw_flag_set_i == 22'h000000;
    endsequence
    sequence maskable_out;
        core_req_o.req && !core_req_o.nmi;
    endsequence
    // ----------------
    // properties
    // ----------------
    // reset must win, so this one is never disabled
    chk_reset_state:
        assert property (disable iff (1'b0) !rst_n_i |=>
            flags_o == 22'h000000 && mask_o == 22'h3fffff)
        else $error("reset state wrong");
    chk_nmi_vector:
        assert property (core_req_o.req && core_req_o.nmi |->
            core_req_o.vector == 16'h0004 && core_req_o.index == 5'h00)
        else $error("nmi vector wrong");
    chk_vector_map:
        assert property (maskable_out |-> core_req_o.vector ==
            16'h0004 + {10'h000, core_req_o.index, 1'b0})
        else $error("vector does not match slot");
    chk_lowest_wins:
        assert property (maskable_out |-> (flags_o & ~mask_o &
            ((22'h000001 << core_req_o.index) - 22'h000001)) == 22'h0)
        else $error("lower pending slot skipped");
    chk_gate_flags:
        assert property (maskable_out |-> flags_o[core_req_o.index] &&
            !mask_o[core_req_o.index])
        else $error("request not qualified");
    chk_wdt_kind:
        assert property ((maskable_out and core_req_o.index == 5'h00) |->
            !$past(wdt_nmi_mode_i))
        else $error("watchdog maskable in nmi mode");
    chk_sw_set:
        assert property ((sw_flag_set_i & 22'h1ffffe) != 22'h0 |=>
            (~flags_o & $past(sw_flag_set_i) & 22'h1ffffe) == 22'h0)
        else $error("software set lost");
    chk_ack_clears:
        assert property (ack_taken |=> !flags_o[$past(core_req_o.index)])
        else $error("ack did not clear flag");
    chk_mask_write:
        assert property (sw_mask_wr_i |=> mask_o == ($past(sw_mask_i) |
            (LARGE_VARIANT ? 22'h000000 : 22'h200000)))
        else $error("mask write wrong");
    chk_slot21_absent:
        assert property (!LARGE_VARIANT |-> !flags_o[21] && mask_o[21])
        else $error("absent slot active");
endmodule // irq_src_properties

bind interrupt_source_priority_vectoring irq_src_properties #(
    .LARGE_VARIANT(LARGE_VARIANT)
) u_irq_src_properties (
    .clock_i       (clock_i),
    .rst_n_i       (rst_n_i),
    .wdt_nmi_mode_i(wdt_nmi_mode_i),
    .sw_flag_set_i (sw_flag_set_i),
    .sw_mask_wr_i  (sw_mask_wr_i),
    .sw_mask_i     (sw_mask_i),
    .ack_i         (ack_i),
    .core_req_o    (core_req_o),
    .flags_o       (flags_o),
    .mask_o        (mask_o)
);

// ==== test/core_model.sv ====
// processor core stand-in that acknowledges presented requests
`timescale 1ns/100ps
module core_model
(
    input  wire logic               clock_i,
    input  wire logic               rst_n_i,
    input  wire irq_pkg::core_req_t core_req_i,
    input  wire logic               auto_ack_i,
    input  wire logic [3:0]         wait_i,
    output logic                    ack_o,
    output logic [15:0]             fetched_o,
    output logic [7:0]              count_o
);
    logic [3:0] wait_reg;
    // idle a cycle after each ack: the old request still stands
    always @(posedge clock_i)
    begin
        ack_o <= 1'b0;
        if (!rst_n_i)
        begin
            wait_reg <= 4'h0;
            count_o <= 8'h00;
        end
        else if (auto_ack_i && core_req_i.req && !ack_o)
        begin
            if (wait_reg == wait_i)
            begin
                ack_o <= 1'b1;
                fetched_o <= core_req_i.vector;
                count_o <= count_o + 8'h01;
                wait_reg <= 4'h0;
            end
            else
                wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule // core_model

// ==== test/test_interrupt_source_priority_vectoring.sv ====
// self-checking bench for the interrupt source block
`timescale 1ns/100ps
module test_interrupt_source_priority_vectoring;
    irq_pkg::periph_events_t   periph_i = '0;
    irq_pkg::core_req_t        core_req_o;
    irq_pkg::edge_mode_t [3:0] ext_edge_mode_i =
        '{default: irq_pkg::EDGE_RISE};
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        wdt_overflow_i = 1'b0;
    logic        wdt_nmi_mode_i = 1'b0;
    logic [3:0]  ext_pin_i = 4'h0;
    logic [1:0]  key_return_i = 2'h3;
    logic [1:0]  key_return_mode_i = 2'h3;
    logic [21:0] sw_flag_set_i = 22'h000000;
    logic [21:0] sw_flag_clr_i = 22'h000000;
    logic        sw_mask_wr_i = 1'b0;
    logic [21:0] sw_mask_i = 22'h000000;
    logic        global_irq_enable_i = 1'b1;
    logic        auto_ack = 1'b0;
    logic [3:0]  ack_wait = 4'h0;
    logic        ack_i;
    logic        wake_o;
    logic [21:0] flags_o;
    logic [21:0] mask_o;
    logic [15:0] fetched;
    logic [7:0]  n_acks;
    int          miscompares = 0;
    int          n_tests = 0;
    int slot_of [0:22] = '{0, 1, 2, 3, 4, 5, 6, 6, 7, 8, 9, 10, 11,
        12, 12, 13, 14, 15, 16, 17, 18, 19, 20};

    always #4 clock_i = ~clock_i;

    interrupt_source_priority_vectoring u_interrupt_source_priority_vectoring (
        .clock_i            (clock_i),
        .rst_n_i            (rst_n_i),
        .wdt_overflow_i     (wdt_overflow_i),
        .wdt_nmi_mode_i     (wdt_nmi_mode_i),
        .ext_pin_i          (ext_pin_i),
        .ext_edge_mode_i    (ext_edge_mode_i),
        .key_return_i       (key_return_i),
        .key_return_mode_i  (key_return_mode_i),
        .periph_i           (periph_i),
        .sw_flag_set_i      (sw_flag_set_i),
        .sw_flag_clr_i      (sw_flag_clr_i),
        .sw_mask_wr_i       (sw_mask_wr_i),
        .sw_mask_i          (sw_mask_i),
        .global_irq_enable_i(global_irq_enable_i),
        .ack_i              (ack_i),
        .core_req_o         (core_req_o),
        .flags_o            (flags_o),
        .mask_o             (mask_o),
        .wake_o             (wake_o)
    );
    core_model u_core_model (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_i),
        .core_req_i(core_req_o),
        .auto_ack_i(auto_ack),
        .wait_i    (ack_wait),
        .ack_o     (ack_i),
        .fetched_o (fetched),
        .count_o   (n_acks)
    );

    // ----------------
    // helpers
    // ----------------
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic summarize;
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_up;
        miscompares++;
        $display("BAD %0t wait ran out", $time);
        summarize();
    endtask
    task automatic set_mask(input logic [21:0] m);
        sw_mask_i = m;
        sw_mask_wr_i = 1'b1;
        tick(1);
        sw_mask_wr_i = 1'b0;
    endtask
    task automatic sw_set(input logic [21:0] f);
        sw_flag_set_i = f;
        tick(1);
        sw_flag_set_i = 22'h000000;
    endtask
    // one-cycle source event; ext pins stay high and the key pin stays low until the caller restores them
    task automatic fire(input int code);
        irq_pkg::periph_events_t ev;
        ev = '0;
        // struct bits from remote_edge down, mode bit skipped
        if (code == 0)
            wdt_overflow_i = 1'b1;
        else if (code < 5)
            ext_pin_i[code - 1] = 1'b1;
        else if (code == 18)
            key_return_i[0] = 1'b0;
        else
            ev[code > 14 && code < 18 ? 21 - code : 22 - code] = 1'b1;
        ev.timer_16bit_mode = (code == 14);
        periph_i = ev;
        tick(1);
        wdt_overflow_i = 1'b0;
        periph_i = '0;
    endtask
    // waits for a request, lets the core model ack it, checks the result
    task automatic serve(input int slot);
        int n;
        logic [7:0] seen;
        for (n = 0; core_req_o.req !== 1'b1; n++)
        begin
            if (n == 20) give_up();
            tick(1);
        end
        seen = n_acks;
        check(core_req_o.index, slot);
        ack_wait = 4'(slot % 4);
        auto_ack = 1'b1;
        for (n = 0; n_acks == seen; n++)
        begin
            if (n == 20) give_up();
            tick(1);
        end
        auto_ack = 1'b0;
        tick(1);
        check(fetched, 16'h0004 + 16'(2 * slot));
        check(flags_o[slot], 1'b0);
    endtask

    // ----------------
    // scenarios
    // ----------------
    task automatic t_reset;
        check(flags_o, 22'h000000);
        check(mask_o, 22'h3fffff);
        check(core_req_o.req, 1'b0);
        check(wake_o, 1'b0);
    endtask
    task automatic t_sources;
        set_mask(22'h000000);
        for (int c = 0; c < 23; c++)
        begin
            fire(c);
            serve(slot_of[c]);
            ext_pin_i = 4'h0;
            key_return_i = 2'h3;
            tick(6);
        end
        check(flags_o, 22'h000000);
    endtask
    task automatic t_priority;
        sw_set(22'h100208);
        serve(3);
        serve(9);
        serve(20);
        set_mask(22'h000008);
        check(mask_o, 22'h200008);
        sw_set(22'h000208);
        serve(9);
        global_irq_enable_i = 1'b0;
        set_mask(22'h000000);
        tick(1);
        check(core_req_o.req, 1'b0);
        check(wake_o, 1'b1);
        global_irq_enable_i = 1'b1;
        serve(3);
    endtask
    task automatic t_nmi;
        set_mask(22'h3fffff);
        global_irq_enable_i = 1'b0;
        wdt_nmi_mode_i = 1'b1;
        sw_set(22'h000001);
        check(flags_o, 22'h000000);
        fire(0);
        check(core_req_o.nmi, 1'b1);
        check(wake_o, 1'b1);
        serve(0);
        wdt_nmi_mode_i = 1'b0;
    endtask
    task automatic t_flags;
        sw_set(22'h200040);
        check(flags_o, 22'h000040);
        sw_flag_clr_i = 22'h000040;
        tick(1);
        sw_flag_clr_i = 22'h000000;
        check(flags_o, 22'h000000);
        sw_set(22'h000300);
        rst_n_i = 1'b0;
        tick(1);
        rst_n_i = 1'b1;
        check(flags_o, 22'h000000);
        check(mask_o, 22'h3fffff);
    endtask

    initial
    begin
        tick(6);
        t_reset();
        rst_n_i = 1'b1;
        tick(8);
        t_sources();
        t_priority();
        t_nmi();
        t_flags();
        summarize();
    end
endmodule // test_interrupt_source_priority_vectoring
